// *** acrf_defs.vh ***
// Register offsets, reset values and field positions of the register file
`ifndef ACRF_DEFS_VH
`define ACRF_DEFS_VH
`define ACRF_ADDR_W 8
`define ACRF_OFF_MODE_CTRL 8'h15
`define ACRF_OFF_SETUP_THREE 8'h17
`define ACRF_OFF_BUF_SETUP 8'h1d
`define ACRF_OFF_OUT_LOW 8'h04
`define ACRF_OFF_OUT_HIGH 8'h05
`define ACRF_OFF_STATUS 8'h14
`define ACRF_OFF_UPPER_LOW 8'h35
`define ACRF_OFF_UPPER_HIGH 8'h36
`define ACRF_OFF_SELF_CHECK 8'h37
`define ACRF_OFF_SPARE_RW 8'h39
`define ACRF_OFF_SPARE_RO 8'h3a
`define ACRF_LAST_ADDR 8'h3a
`define ACRF_RST_UPPER_LOW_GND 8'h00
`define ACRF_RST_UPPER_LOW_VDD 8'h40
`define ACRF_RST_UPPER_HIGH 4'h0
`define ACRF_RST_SELF_CHECK 8'h00
`define ACRF_RST_SPARE_RW 8'h00
`define ACRF_RST_SPARE_RO 8'h00
`define ACRF_RST_SETUP_THREE 8'h00
`define ACRF_RST_BUF_SETUP 8'h00
`define ACRF_BIT_ACTIVE 0
`define ACRF_BIT_SOFT_RST 7
`define ACRF_BIT_EXTERNAL_TRIGGER_MODE 1
`define ACRF_BIT_BYTE_ORDER 0
`define ACRF_BIT_FLUSH 7
`endif

// *** acrf_top.v ***
// Control register file tail with mode-dependent write protection
`timescale 1ns/1ns
`include "acrf_defs.vh"

// Operation
// (R01) Retained registers kept entering standby
// (R02) Defaults restored on hibernate exit or reset
// (R03) Output registers cleared on standby-to-run
// (R04) Output bytes ordered by byte order select
// (R05) Byte order defaults little-endian right-justified
// (R06) Buffer invalidated on standby-to-run
// (R07) Protected writes ignored outside standby
// (R08) Active, reset, flush bits writable always; the code ignores active bit writes in external trigger
// (R09) Active bit frozen in external trigger
// (R10) Upper limit low byte, strap default
// (R11) Upper limit high four bits, zero default
// (R12) Self-check idle duration register, zero reset
// (R13) Host leaves factory spare register alone
// (R14) Pointer increments, wraps past last register
module acrf_top (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire wake_mode_strap_i,
    input wire hibernate_exit_i,
    input wire [11:0] sample_i,
    input wire sample_valid_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire burst_i,
    output reg [7:0] rdata_o,
    output reg [7:0] pointer_o,
    output reg [7:0] run_mode_o,
    output reg [11:0] upper_limit_o,
    output reg [7:0] self_check_idle_o,
    output reg buf_invalid_o,
    output reg buf_flush_o,
    output reg soft_reset_o
);

    // Operating modes, one-hot
    localparam [2:0] ST_STANDBY = 3'b001;
    localparam [2:0] ST_ACTIVE = 3'b010;
    localparam [2:0] ST_EXT = 3'b100;

    // Pin synchroniser stages
    // Strap is a static level but still crosses in
    // Hibernate pin also keeps a delayed copy for edge finding
    reg strap_m_r;
    reg strap_s_r;
    reg hib_m_r;
    reg hib_s_r;
    reg hib_d_r;

    // Operating mode and its next value
    reg [2:0] mode_r;
    reg [2:0] mode_nxt;

    // Mode control bits
    // Active bit writable in any mode but external trigger
    // Trigger select only writable in standby
    reg active_bit_r;
    reg ext_sel_r;

    // Retained configuration registers
    // All kept across a return to standby
    reg [7:0] setup_three_r;
    reg [7:0] buf_setup_r;
    reg [7:0] upper_low_r;
    reg [3:0] upper_high_r;
    reg [7:0] self_check_r;
    reg [7:0] spare_rw_r;

    // Latest output sample, cleared on run entry
    reg [11:0] out_r;

    // Start-up counter, defaults reloaded until strap settles
    // Three edges: two synchroniser stages plus the load itself
    reg [1:0] init_cnt_r;

    // Combinational readback value
    reg [7:0] rd_val;

    // Rising edge of the synchronised hibernate pin
    wire hib_exit = hib_s_r & ~hib_d_r;
    // Mode decodes, one-hot so a single bit each
    wire standby = mode_r[0];
    // Protected writes only land in standby
    wire wr_ok = wr_i & standby; // (R07)
    // Standby to either running mode this cycle
    wire leave_standby = standby & ~mode_nxt[0];
    // Soft reset write or hibernate exit restores defaults
    wire clear_all = hib_exit | (wr_i & (addr_i == `ACRF_OFF_MODE_CTRL) & wdata_i[`ACRF_BIT_SOFT_RST]);
    // Still waiting for the strap to pass the synchroniser
    wire init_pend = (init_cnt_r != 2'd3);

    // Strap and hibernate pin synchronisers
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_m_r <= 1'b0;
            strap_s_r <= 1'b0;
            hib_m_r <= 1'b0;
            hib_s_r <= 1'b0;
            hib_d_r <= 1'b0;
        end else begin
            strap_m_r <= wake_mode_strap_i;
            strap_s_r <= strap_m_r;
            hib_m_r <= hibernate_exit_i;
            hib_s_r <= hib_m_r;
            hib_d_r <= hib_s_r;
        end
    end

    // Next mode from active bit and trigger select
    // Standby leaves only once the active bit is set
    // Trigger select picks which running mode is entered
    // Either running mode drops back when active clears
    // Mode follows the active bit one cycle later
    always @* begin
        mode_nxt = ST_STANDBY;
        case (mode_r)
            ST_STANDBY: begin
                if (active_bit_r) begin
                    if (ext_sel_r) begin
                        mode_nxt = ST_EXT;
                    end else begin
                        mode_nxt = ST_ACTIVE;
                    end
                end else begin
                    mode_nxt = ST_STANDBY;
                end
            end
            ST_ACTIVE: begin
                if (active_bit_r) begin
                    mode_nxt = ST_ACTIVE;
                end else begin
                    mode_nxt = ST_STANDBY;
                end
            end
            ST_EXT: begin
                if (active_bit_r) begin
                    mode_nxt = ST_EXT;
                end else begin
                    mode_nxt = ST_STANDBY;
                end
            end
            default: begin
                // Illegal code, fall back to the safe mode
                mode_nxt = ST_STANDBY;
            end
        endcase
    end

    // Readback mux, output bytes ordered by byte order select
    // Byte order set: high bits first, left justified
    // Byte order clear: low bits first, right justified
    // Unmapped addresses read as zero
    // Read-only spare always shows its fixed value
    always @* begin
        case (addr_i)
            `ACRF_OFF_OUT_LOW: rd_val = setup_three_r[`ACRF_BIT_BYTE_ORDER] ? out_r[11:4] : out_r[7:0]; // (R04)
            `ACRF_OFF_OUT_HIGH: rd_val = setup_three_r[`ACRF_BIT_BYTE_ORDER] ? {out_r[3:0], 4'h0} :
                {4'h0, out_r[11:8]}; // (R04)
            `ACRF_OFF_STATUS: rd_val = {buf_invalid_o, 4'h0, mode_r};
            `ACRF_OFF_MODE_CTRL: rd_val = {7'h00, active_bit_r};
            `ACRF_OFF_SETUP_THREE: rd_val = setup_three_r;
            `ACRF_OFF_BUF_SETUP: rd_val = buf_setup_r;
            `ACRF_OFF_UPPER_LOW: rd_val = upper_low_r;
            `ACRF_OFF_UPPER_HIGH: rd_val = {4'h0, upper_high_r};
            `ACRF_OFF_SELF_CHECK: rd_val = self_check_r;
            `ACRF_OFF_SPARE_RW: rd_val = spare_rw_r;
            `ACRF_OFF_SPARE_RO: rd_val = `ACRF_RST_SPARE_RO;
            default: rd_val = 8'h00;
        endcase
    end

    // Mode, control bits and register storage
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r <= ST_STANDBY;
            active_bit_r <= 1'b0;
            ext_sel_r <= 1'b0;
            setup_three_r <= `ACRF_RST_SETUP_THREE; // (R05)
            buf_setup_r <= `ACRF_RST_BUF_SETUP;
            upper_low_r <= `ACRF_RST_UPPER_LOW_GND; // (R02)
            upper_high_r <= `ACRF_RST_UPPER_HIGH;
            self_check_r <= `ACRF_RST_SELF_CHECK;
            spare_rw_r <= `ACRF_RST_SPARE_RW;
            out_r <= 12'h000;
            buf_invalid_o <= 1'b0;
            buf_flush_o <= 1'b0;
            soft_reset_o <= 1'b0;
            init_cnt_r <= 2'd0;
        end else if (clear_all | init_pend) begin
            // Defaults, upper limit low from synchronised strap
            // Reloaded each start-up edge so the last load sees the pin
            // Bus writes in these cycles are lost, host must wait
            mode_r <= ST_STANDBY; // (R02)
            active_bit_r <= 1'b0;
            ext_sel_r <= 1'b0;
            setup_three_r <= `ACRF_RST_SETUP_THREE; // (R05)
            buf_setup_r <= `ACRF_RST_BUF_SETUP;
            upper_low_r <= strap_s_r ? `ACRF_RST_UPPER_LOW_VDD : `ACRF_RST_UPPER_LOW_GND; // (R10)
            upper_high_r <= `ACRF_RST_UPPER_HIGH; // (R11)
            self_check_r <= `ACRF_RST_SELF_CHECK; // (R12)
            spare_rw_r <= `ACRF_RST_SPARE_RW;
            out_r <= 12'h000;
            buf_invalid_o <= 1'b0;
            buf_flush_o <= 1'b0;
            soft_reset_o <= clear_all & ~hib_exit;
            if (init_pend) begin
                init_cnt_r <= init_cnt_r + 2'd1;
            end
        end else begin
            // Retained registers untouched when returning to standby
            mode_r <= mode_nxt; // (R01)
            // Pulses last one cycle
            soft_reset_o <= 1'b0;
            buf_flush_o <= 1'b0;
            // Run entry wins over a sample arriving in the same cycle
            // Samples are only taken while running
            if (leave_standby) begin
                out_r <= 12'h000; // (R03)
                buf_invalid_o <= 1'b1; // (R06)
            end else if (sample_valid_i & ~standby) begin
                out_r <= sample_i;
                buf_invalid_o <= 1'b0;
            end
            // Always-writable control bits
            // Active bit held while in external trigger
            if (wr_i & (addr_i == `ACRF_OFF_MODE_CTRL) & ~mode_r[2]) begin
                active_bit_r <= wdata_i[`ACRF_BIT_ACTIVE]; // (R08) (R09)
            end
            // Flush marks the buffer stale, set wins over a sample
            if (wr_i & (addr_i == `ACRF_OFF_BUF_SETUP) & wdata_i[`ACRF_BIT_FLUSH]) begin
                buf_flush_o <= 1'b1; // (R08)
                buf_invalid_o <= 1'b1;
            end
            // Protected registers, standby only
            // Flush bit self-clears, never stored
            // Upper limit high keeps only four bits
            if (wr_ok) begin
                case (addr_i)
                    `ACRF_OFF_MODE_CTRL: ext_sel_r <= wdata_i[`ACRF_BIT_EXTERNAL_TRIGGER_MODE]; // (R07)
                    `ACRF_OFF_SETUP_THREE: setup_three_r <= wdata_i; // (R07)
                    `ACRF_OFF_BUF_SETUP: buf_setup_r <= {1'b0, wdata_i[6:0]}; // (R07)
                    `ACRF_OFF_UPPER_LOW: upper_low_r <= wdata_i; // (R10)
                    `ACRF_OFF_UPPER_HIGH: upper_high_r <= wdata_i[3:0]; // (R11)
                    `ACRF_OFF_SELF_CHECK: self_check_r <= wdata_i; // (R12)
                    `ACRF_OFF_SPARE_RW: spare_rw_r <= wdata_i; // (R13)
                    default: spare_rw_r <= spare_rw_r;
                endcase
            end
        end
    end

    // Read data, pointer and mirrored outputs
    // Read data stands for one cycle, zero otherwise
    // Pointer steps by one in burst access, wraps past the last register
    // Single access leaves the pointer on the address used
    // Mirrors lag their registers by one cycle
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
            pointer_o <= 8'h00;
            run_mode_o <= 8'h00;
            upper_limit_o <= 12'h000;
            self_check_idle_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rd_val : 8'h00;
            if (rd_i | wr_i) begin
                if (burst_i) begin
                    pointer_o <= (addr_i >= `ACRF_LAST_ADDR) ? 8'h00 : addr_i + 8'h01; // (R14)
                end else begin
                    pointer_o <= addr_i;
                end
            end
            run_mode_o <= {5'h00, mode_r};
            upper_limit_o <= {upper_high_r, upper_low_r};
            self_check_idle_o <= self_check_r;
        end
    end

endmodule

// *** acrf_asserts.sv ***
// Checker of mode protection, pointer stepping and pulses
`timescale 1ns/1ns
module acrf_asserts (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire burst_i,
    input wire [7:0] pointer_o,
    input wire [7:0] run_mode_o,
    input wire [11:0] upper_limit_o,
    input wire [7:0] self_check_idle_o,
    input wire buf_invalid_o,
    input wire buf_flush_o,
    input wire soft_reset_o
);
    reg [1:0] quiet_r;
    wire ctl_wr = wr_i && addr_i == 8'h15;
    wire calm = quiet_r == 2'd3;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Cycles since the last mode control write, so mode output has settled
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            quiet_r <= 2'd0;
        else if (ctl_wr)
            quiet_r <= 2'd0;
        else if (!calm)
            quiet_r <= quiet_r + 2'd1;
    end
    sequence s_go_run;
        ctl_wr && wdata_i[1:0] == 2'b01 && !wdata_i[7] && calm && run_mode_o == 8'h01;
    endsequence
    a_run_invalid: assert property (s_go_run |-> ##3 buf_invalid_o ##1 run_mode_o == 8'h02)
        else $error("no invalidate");
    a_ptr_step: assert property ((wr_i || rd_i) && burst_i && addr_i < 8'h3a |=> pointer_o == $past(addr_i) + 8'h01)
        else $error("bad step");
    a_ptr_wrap: assert property ((wr_i || rd_i) && burst_i && addr_i == 8'h3a |=> pointer_o == 8'h00)
        else $error("bad wrap");
    a_guard_limit: assert property (wr_i && addr_i == 8'h35 && calm && !run_mode_o[0] |=> ##1 $stable(upper_limit_o))
        else $error("guard broken");
    a_take_idle: assert property (wr_i && addr_i == 8'h37 && calm && run_mode_o[0] |-> ##3 self_check_idle_o == $past(wdata_i, 3))
        else $error("write lost");
    a_ext_hold: assert property (ctl_wr && !wdata_i[7] && calm && run_mode_o == 8'h04 |=> run_mode_o == 8'h04 [*4])
        else $error("mode left");
    a_flush_pulse: assert property (wr_i && addr_i == 8'h1d && wdata_i[7] |-> ##[1:2] buf_flush_o)
        else $error("no flush");
    a_soft_pulse: assert property (ctl_wr && wdata_i[7] |-> ##[1:2] soft_reset_o)
        else $error("no reset");
endmodule
bind acrf_top acrf_asserts chk_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .burst_i(burst_i), .pointer_o(pointer_o),
    .run_mode_o(run_mode_o), .upper_limit_o(upper_limit_o), .self_check_idle_o(self_check_idle_o),
    .buf_invalid_o(buf_invalid_o), .buf_flush_o(buf_flush_o), .soft_reset_o(soft_reset_o));

// *** acrf_host.sv ***
// Host model issuing register bus cycles
`timescale 1ns/1ns
module acrf_host (
    input wire core_clk_i,
    output reg [7:0] addr_o = 8'h00,
    output reg [7:0] wdata_o = 8'h00,
    output reg wr_o = 1'b0,
    output reg rd_o = 1'b0
);
    // One write or read cycle; the spare register is never written
    task cyc(input w, input [7:0] a, input [7:0] d);
        begin
            @(posedge core_clk_i);
            addr_o <= a;
            wdata_o <= d;
            wr_o <= w && a != 8'h39;
            rd_o <= !w;
            @(posedge core_clk_i);
            wr_o <= 1'b0;
            rd_o <= 1'b0;
        end
    endtask
endmodule

// *** accel_register_file_rules_test.sv ***
// Bench for the register file tail
`timescale 1ns/1ns
module accel_register_file_rules_test;
    reg clk = 0, rst_n = 0, strap = 0, hib = 0, sv = 0, burst = 0;
    reg [11:0] smp = 12'h000;
    reg [7:0] lf = 8'h57, v;
    wire [7:0] addr, wdata, rdata, ptr, mode;
    wire wr, rd;
    integer err_total = 0, checked = 0, i;
    always #10 clk = ~clk;
    acrf_host host (.core_clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    acrf_top dut (.core_clk_i(clk), .rst_n_i(rst_n), .wake_mode_strap_i(strap), .hibernate_exit_i(hib),
        .sample_i(smp), .sample_valid_i(sv), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .burst_i(burst), .rdata_o(rdata), .pointer_o(ptr), .run_mode_o(mode), .upper_limit_o(),
        .self_check_idle_o(), .buf_invalid_o(), .buf_flush_o(), .soft_reset_o());
    function [7:0] nxt(input [7:0] s);
        nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task chk(input [31:0] nm, input [7:0] e, input [7:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // Read one register and compare the answer
    task rdc(input [7:0] a, input [7:0] e);
        begin
            host.cyc(1'b0, a, 8'h00);
            @(negedge clk);
            chk("rd", e, rdata);
        end
    endtask
    task give_verdict;
        begin
            if (err_total == 0 && checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // Watchdog
    initial begin
        #100000;
        err_total = err_total + 1;
        give_verdict;
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rdc(8'h35, 8'h00);
        rdc(8'h36, 8'h00);
        rdc(8'h17, 8'h00);
        rdc(8'h39, 8'h00);
        rdc(8'h50, 8'h00);
        chk("ptr", 8'h50, ptr);
        @(posedge clk);
        burst <= 1'b1;
        rdc(8'h3a, 8'h00);
        chk("ptr", 8'h00, ptr);
        for (i = 0; i < 4; i = i + 1) begin
            lf = nxt(lf);
            host.cyc(1'b1, 8'h37, lf);
            host.cyc(1'b1, 8'h35, lf);
            rdc(8'h37, lf);
        end
        v = lf;
        for (i = 0; i < 2; i = i + 1) begin
            host.cyc(1'b1, 8'h17, i[7:0]);
            host.cyc(1'b1, 8'h15, 8'h01);
            repeat (4) @(posedge clk);
            rdc(8'h04, 8'h00);
            lf = nxt(lf);
            @(posedge clk);
            smp <= {lf[3:0], lf};
            sv <= 1'b1;
            @(posedge clk);
            sv <= 1'b0;
            rdc(8'h04, i ? smp[11:4] : smp[7:0]);
            rdc(8'h05, i ? {smp[3:0], 4'h0} : {4'h0, smp[11:8]});
            host.cyc(1'b1, 8'h35, ~v);
            host.cyc(1'b1, 8'h15, 8'h00);
            repeat (4) @(posedge clk);
            rdc(8'h35, v);
            rdc(8'h37, v);
        end
        host.cyc(1'b1, 8'h15, 8'h03);
        repeat (4) @(posedge clk);
        host.cyc(1'b1, 8'h15, 8'h02);
        repeat (4) @(negedge clk);
        chk("mode", 8'h04, mode);
        host.cyc(1'b1, 8'h1d, 8'h80);
        host.cyc(1'b1, 8'h15, 8'h80);
        repeat (4) @(negedge clk);
        chk("mode", 8'h01, mode);
        rdc(8'h37, 8'h00);
        host.cyc(1'b1, 8'h37, 8'h5a);
        strap <= 1'b1;
        repeat (4) @(posedge clk);
        hib <= 1'b1;
        repeat (6) @(posedge clk);
        hib <= 1'b0;
        rdc(8'h35, 8'h40);
        rdc(8'h37, 8'h00);
        give_verdict;
    end
endmodule
